// [hdl/qmm_consts.svh]
// Constants for the module management and status block
`ifndef QMM_CONSTS_SVH
`define QMM_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define QMM_OFS_STATUS 8'h00
`define QMM_OFS_FLAGS 8'h04
`define QMM_OFS_MASK 8'h08
`define QMM_OFS_CTRL 8'h0C

// ==========================================================
// Field positions and widths
`define QMM_FLAG_W 9
`define QMM_COND_W 8
`define QMM_FLAG_RXLOS 0
`define QMM_FLAG_READY 8
`define QMM_CTRL_PDOWN 0

// ==========================================================
// Reset values
`define QMM_MASK_RST 9'h000
`define QMM_CTRL_RST 1'h0
// Idle pin levels {scl, sda, mrst_n, sel_n, lp, cond}: no false edge after reset
`define QMM_PINS_IDLE 13'h1E00

// ==========================================================
// Timing: clock period and data ready time
`define QMM_CLK_NS 100
`define QMM_T_DATA_MS 2000
`define QMM_READY_CYC (32'(`QMM_T_DATA_MS * 64'd1000000 / `QMM_CLK_NS))

// AXI response codes
`define QMM_RESP_OKAY 2'h0
`define QMM_RESP_SLVERR 2'h2

`endif

// [hdl/qmm_pkg.sv]
// Types shared by the module management and status block
package qmm_pkg;

   // ==========================================================
   // Start-up sequence states, one-hot
   typedef enum logic [2:0] {
      QMM_ST_HOLD = 3'h1, // Module reset pin held low
      QMM_ST_WAIT = 3'h2, // Counting toward data ready
      QMM_ST_READY = 3'h4 // Fully functional
   } qmm_state_t;

   // ==========================================================
   // Status word shown to software
   typedef struct packed {
      logic bus_busy;   // Serial bus between start and stop
      logic respond;    // Serial bus responses enabled
      logic power_low;  // Lower power level in force
      logic not_ready;  // Monitor data not yet ready
   } qmm_status_t;

   // Synchronised pin bundle
   typedef struct packed {
      logic scl;        // Serial clock
      logic sda;        // Serial data
      logic mrst_n;     // Module reset, active low
      logic sel_n;      // Module select, active low
      logic lp;         // Low power pin
      logic [7:0] cond; // Flag conditions
   } qmm_pins_t;

endpackage : qmm_pkg

// [hdl/qmm_top.sv]
// Management, status and interrupt logic of a pluggable transceiver module
// Notes on behaviour
// R1 - Data ready and interrupt within 2000 ms
// R2 - Fully functional within 2000 ms after reset
// R3 - Ready shown by interrupt plus cleared bit
// R4 - Low power pin lowers power within 100 us
// R5 - Interrupt condition pulls output low fast
// R6 - Flag read clears it, releases interrupt
// R7 - Receive signal loss sets flag quickly
// R8 - Other conditions set their flag quickly
// R9 - Setting mask inhibits that flag's interrupt
// R10 - Clearing mask lets flag interrupt again
// R11 - Mask and power timing from write end
// R12 - Select low enables serial responses
// R13 - Select high stops serial responses
// R14 - Power-down bit enters lower power level
// R15 - Clearing power-down restores full function
// R16 - Host reads flags after interrupt
// R17 - Host drives serial clock, edges defined
// R18 - Interrupt held while unmasked flag set
`timescale 1ns/10ps
`include "qmm_consts.svh"

module qmm_top
   import qmm_pkg::*;
#(
   parameter int unsigned READY_CYC = `QMM_READY_CYC // Cycles to data ready
)
(
   input wire logic aclk, // 10 MHz clock
   input wire logic aresetn, // Power-on reset, active low, synchronous
   input wire logic ce, // Clock enable, freezes state when low
   input wire logic module_reset_n, // Module reset pin
   input wire logic module_select_n, // Module select pin
   input wire logic low_power_pin, // Low power pin
   input wire logic scl, // Serial clock pin
   input wire logic sda_in, // Serial data pin level
   input wire logic [`QMM_COND_W-1:0] cond_in, // Flag conditions, bit 0 receive loss
   output logic irq_out_n_q, // Interrupt output, active low
   output logic power_low_q, // Lower power level request
   output logic twi_respond_q, // Serial bus responses enabled
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);

   // ==========================================================
   // Declarations
   qmm_pins_t pin_raw; // Pins before synchronising
   qmm_pins_t sync1_q; // First synchroniser stage
   qmm_pins_t sync2_q; // Second synchroniser stage
   logic scl_prev_q; // Serial clock one cycle back
   logic sda_prev_q; // Serial data one cycle back
   logic bus_busy_q; // Start seen, stop not yet
   logic mrst_prev_q; // Module reset one cycle back
   qmm_state_t state_q; // Start-up sequence state
   logic [31:0] ready_cnt_q; // Data ready counter
   logic not_ready_q; // Data not ready status bit
   logic ready_evt; // Data ready reached this cycle
   logic [`QMM_FLAG_W-1:0] flags_q; // Sticky flags
   logic [`QMM_FLAG_W-1:0] mask_q; // Interrupt masks
   logic [`QMM_FLAG_W-1:0] set_vec; // Flags set this cycle
   logic [`QMM_FLAG_W-1:0] clr_vec; // Flags cleared by a read
   logic pdown_q; // Power-down control bit
   logic [7:0] awaddr_q; // Held write address
   logic [31:0] wdata_q; // Held write data
   logic [3:0] wstrb_q; // Held write strobes
   logic aw_full_q; // Write address held
   logic w_full_q; // Write data held
   logic wr_go; // Write performed this cycle
   logic rd_go; // Read taken this cycle
   logic rd_flags_evt; // Flag register read this cycle
   qmm_status_t status; // Status word

   assign pin_raw = '{scl: scl, sda: sda_in, mrst_n: module_reset_n, sel_n: module_select_n,
                      lp: low_power_pin, cond: cond_in};

   // ==========================================================
   // Two-stage synchroniser for every pin
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_q <= `QMM_PINS_IDLE; // Idle levels, no false reset or select edge
         sync2_q <= `QMM_PINS_IDLE;
      end
      else if (ce)
      begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   // ==========================================================
   // Serial bus watch: clock sampled, start and stop found
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         bus_busy_q <= 1'b0;
      end
      else if (ce)
      begin
         scl_prev_q <= sync2_q.scl;
         sda_prev_q <= sync2_q.sda;
         // Data changes only while clock low; a change with clock high is framing [R17]
         if (sync2_q.scl && scl_prev_q && sda_prev_q && !sync2_q.sda)
            bus_busy_q <= 1'b1; // Start
         else if (sync2_q.scl && scl_prev_q && !sda_prev_q && sync2_q.sda)
            bus_busy_q <= 1'b0; // Stop
      end
   end

   // ==========================================================
   // Bus response gate follows the select pin
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         twi_respond_q <= 1'b0;
      else if (ce)
         twi_respond_q <= !sync2_q.sel_n; // [R12] [R13]
   end

   // ==========================================================
   // Start-up sequence: power-on or module reset release to ready
   assign ready_evt = (state_q == QMM_ST_WAIT) && (ready_cnt_q == READY_CYC - 32'h1);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= QMM_ST_WAIT;
         ready_cnt_q <= 32'h0;
         not_ready_q <= 1'b1;
         mrst_prev_q <= 1'b1;
      end
      else if (ce)
      begin
         mrst_prev_q <= sync2_q.mrst_n;
         case (state_q)
            QMM_ST_HOLD:
            begin
               // Restart on rising edge of module reset [R2]
               not_ready_q <= 1'b1;
               ready_cnt_q <= 32'h0;
               if (sync2_q.mrst_n && !mrst_prev_q)
                  state_q <= QMM_ST_WAIT;
            end
            QMM_ST_WAIT:
            begin
               if (!sync2_q.mrst_n)
                  state_q <= QMM_ST_HOLD;
               else if (ready_evt)
               begin
                  // Data ready: clear status bit, ready flag raises interrupt [R1] [R3]
                  not_ready_q <= 1'b0;
                  state_q <= QMM_ST_READY;
               end
               else
                  ready_cnt_q <= ready_cnt_q + 32'h1;
            end
            QMM_ST_READY:
            begin
               if (!sync2_q.mrst_n)
                  state_q <= QMM_ST_HOLD;
            end
            default:
               state_q <= QMM_ST_HOLD;
         endcase
      end
   end

   // ==========================================================
   // Sticky flags: set wins over clear-on-read
   assign set_vec = {ready_evt, sync2_q.cond}; // [R7] [R8]
   assign clr_vec = rd_flags_evt ? flags_q : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_q <= '0;
      else if (ce)
      begin
         if (state_q == QMM_ST_HOLD)
            flags_q <= '0; // Module reset empties the flags
         else
            flags_q <= (flags_q & ~clr_vec) | set_vec; // [R6] [R7] [R8]
      end
   end

   // ==========================================================
   // Interrupt output: low while any unmasked flag is set
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_out_n_q <= 1'b1;
      else if (ce)
         irq_out_n_q <= !(|(flags_q & ~mask_q)); // [R5] [R9] [R10] [R18]
   end

   // ==========================================================
   // Power level: pin or power-down bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         power_low_q <= 1'b0;
      else if (ce)
         power_low_q <= sync2_q.lp | pdown_q; // [R4] [R14] [R15]
   end

   // ==========================================================
   // AXI write channel: address and data taken in either order
   assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `QMM_RESP_OKAY;
      end
      else if (ce)
      begin
         // Address handshake
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q <= s_axi_awaddr;
            aw_full_q <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         // Data handshake
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_full_q <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // Both held: write and answer
         if (wr_go)
         begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_q == `QMM_OFS_MASK || awaddr_q == `QMM_OFS_CTRL)
               s_axi_bresp <= `QMM_RESP_OKAY;
            else
               s_axi_bresp <= `QMM_RESP_SLVERR;
         end
         // Response taken: reopen both channels
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Mask and power-down registers, take effect at the write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mask_q <= `QMM_MASK_RST;
         pdown_q <= `QMM_CTRL_RST;
      end
      else if (ce && wr_go && wstrb_q[0])
      begin
         if (awaddr_q == `QMM_OFS_MASK)
         begin
            mask_q[7:0] <= wdata_q[7:0]; // [R9] [R10] [R11]
            if (wstrb_q[1])
               mask_q[8] <= wdata_q[8];
         end
         else if (awaddr_q == `QMM_OFS_CTRL)
            pdown_q <= wdata_q[`QMM_CTRL_PDOWN]; // [R11] [R14] [R15]
      end
   end

   // ==========================================================
   // AXI read channel: one cycle to data
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign rd_flags_evt = rd_go && (s_axi_araddr == `QMM_OFS_FLAGS);
   assign status = '{bus_busy: bus_busy_q, respond: twi_respond_q, power_low: power_low_q,
                     not_ready: not_ready_q};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `QMM_RESP_OKAY;
      end
      else if (ce)
      begin
         if (rd_go)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `QMM_RESP_OKAY;
            case (s_axi_araddr)
               `QMM_OFS_STATUS: s_axi_rdata <= {28'h0, status};
               `QMM_OFS_FLAGS: s_axi_rdata <= {23'h0, flags_q}; // Cleared by this read [R6] [R16]
               `QMM_OFS_MASK: s_axi_rdata <= {23'h0, mask_q};
               `QMM_OFS_CTRL: s_axi_rdata <= {31'h0, pdown_q};
               default:
               begin
                  s_axi_rdata <= 32'h0;
                  s_axi_rresp <= `QMM_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Assertions
   a_ready_done: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R1]
      ready_evt && sync2_q.mrst_n |=> !not_ready_q && flags_q[`QMM_FLAG_READY]
         ##1 (mask_q[`QMM_FLAG_READY] || !irq_out_n_q))
      else $error("data ready not shown");
   a_hold_notready: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R2]
      state_q == QMM_ST_HOLD |=> not_ready_q && flags_q == '0)
      else $error("module reset not held");
   a_ready_count: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R3]
      state_q == QMM_ST_WAIT && !ready_evt && sync2_q.mrst_n |=> ready_cnt_q == $past(ready_cnt_q) + 32'h1)
      else $error("ready counter stalled");
   a_rxlos_set: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R7]
      sync2_q.cond[0] && state_q != QMM_ST_HOLD |=> flags_q[`QMM_FLAG_RXLOS] ##1 (mask_q[0] || !irq_out_n_q))
      else $error("receive loss flag late");
   a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R8]
      |sync2_q.cond[7:1] && state_q != QMM_ST_HOLD |=> |(flags_q[7:1] & $past(sync2_q.cond[7:1])))
      else $error("flag not set");
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R5] [R18]
      |(flags_q & ~mask_q) |=> !irq_out_n_q)
      else $error("interrupt not asserted");
   a_read_release: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R6]
      rd_flags_evt && set_vec == '0 ##1 set_vec == '0 |=> irq_out_n_q)
      else $error("interrupt not released after read");
   a_mask_inhibit: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R9]
      !(|(flags_q & ~mask_q)) |=> irq_out_n_q)
      else $error("masked flag drives interrupt");
   a_unmask_resume: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R10]
      |($past(mask_q) & ~mask_q & flags_q) |=> !irq_out_n_q)
      else $error("unmask did not resume interrupt");
   a_select_on: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R12]
      $fell(sync2_q.sel_n) |=> twi_respond_q)
      else $error("select did not enable bus");
   a_select_off: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R13]
      $rose(sync2_q.sel_n) |=> !twi_respond_q)
      else $error("deselect did not stop bus");
   a_power_low: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R4] [R14]
      sync2_q.lp || pdown_q |=> power_low_q)
      else $error("lower power not entered");
   a_power_full: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R15]
      !sync2_q.lp && !pdown_q |=> !power_low_q)
      else $error("full power not restored");
   a_pdown_write: assert property (@(posedge aclk) disable iff (!aresetn || !ce) // [R11]
      wr_go && wstrb_q[0] && awaddr_q == `QMM_OFS_CTRL |=> pdown_q == $past(wdata_q[0])
         ##1 power_low_q == (pdown_q | $past(sync2_q.lp)))
      else $error("power-down write not applied");

endmodule : qmm_top

// [tb/qmm_host_bfm.sv]
// Host controller model: module pins and 2-wire bus master
`timescale 1ns/10ps

module qmm_host_bfm
(
   input wire logic aclk, // Bench clock
   output logic mrst_n, // Module reset drive
   output logic sel_n, // Module select drive
   output logic lp, // Low power drive
   output logic scl, // Serial clock, idle high
   output logic sda // Serial data as seen with pull-up
);
   // ==========================================================
   // Idle levels: module out of reset, deselected
   initial
   begin
      mrst_n = 1'b1;
      sel_n = 1'b1;
      lp = 1'b0;
      scl = 1'b1;
      sda = 1'b1;
   end

   // ==========================================================
   // Pin changes land just after a clock edge
   task automatic pins(input logic r, input logic s, input logic l);
   begin
      @(posedge aclk);
      mrst_n <= r;
      sel_n <= s;
      lp <= l;
   end
   endtask : pins

   // ==========================================================
   // One frame; clock runs only inside it, 800 ns period
   task automatic frame(input logic [7:0] b);
   begin
      #130 sda = 1'b0; // Start: data falls while clock high
      for (int i = 7; i >= -1; i--)
      begin
         #400 scl = 1'b0; // Data changes only while clock low
         sda = (i >= 0) ? b[i] : 1'b1; // Ack slot released, pull-up wins
         #400 scl = 1'b1; // Device takes data on rising edge
      end
      #400 scl = 1'b0;
      sda = 1'b0;
      #400 scl = 1'b1;
      #400 sda = 1'b1; // Stop: data rises while clock high
   end
   endtask : frame
endmodule : qmm_host_bfm

// [tb/qmm_top_tb.sv]
// Self-checking bench for the module management and status block
`timescale 1ns/10ps
`include "qmm_consts.svh"

module qmm_top_tb;
   // ==========================================================
   // Timing limits in 100 ns cycles
   localparam int RDY = 50; // Shortened data ready count
   localparam int T_US = 1000; // 100 us
   localparam int T_CLR = 5000; // 500 us
   localparam int T_MS = 2000; // Cap on ms-scale waits

   logic aclk = 1'b0, aresetn = 1'b0; // Clock and power-on reset
   logic [7:0] cond = 8'h00, awaddr = 8'h00, araddr = 8'h00; // Conditions, addresses
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // Handshakes
   logic [31:0] wdata = 32'h0, r; // Write data, random word
   logic irq_n, pwr_low, respond, awready, wready, bvalid, arready, rvalid; // Outputs
   logic [1:0] bresp, rresp; // Responses
   logic [31:0] rdata; // Read data
   logic [8:0] m; // Chosen mask bit
   wire logic mrst_n, sel_n, lp, scl, sda; // Host pins
   wire logic [2:0] pins = {respond, pwr_low, irq_n}; // Watched pin outputs
   int mismatches = 0, compares = 0; // Counters
   logic [33:0] rd_q[$]; // Expected read response and data
   logic [1:0] wr_q[$]; // Expected write response

   always #50 aclk = ~aclk;

   qmm_top #(.READY_CYC(RDY)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .module_reset_n(mrst_n), .module_select_n(sel_n),
      .low_power_pin(lp), .scl(scl), .sda_in(sda), .cond_in(cond), .irq_out_n_q(irq_n),
      .power_low_q(pwr_low), .twi_respond_q(respond), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   qmm_host_bfm i_host (.aclk(aclk), .mrst_n(mrst_n), .sel_n(sel_n), .lp(lp), .scl(scl), .sda(sda));

   // ==========================================================
   // Monitor: each bus answer is compared with the oldest note
   always @(posedge aclk)
   begin
      if (rvalid === 1'b1 && rready === 1'b1)
      begin
         compares++;
         if (rd_q.size() == 0 || {rresp, rdata} !== rd_q.pop_front())
         begin
            $display("unexpected read at %0t: %h", $time, {rresp, rdata});
            mismatches++;
         end
      end
      if (bvalid === 1'b1 && bready === 1'b1)
      begin
         compares++;
         if (wr_q.size() == 0 || bresp !== wr_q.pop_front())
         begin
            $display("unexpected write response at %0t: %h", $time, bresp);
            mismatches++;
         end
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
   begin
      compares++;
      if (got !== exp)
      begin
         $display("unexpected value at %0t: %h not %h", $time, got, exp);
         mismatches++;
      end
   end
   endtask : check

   // Waits a bounded time for a pin output to reach a level
   task automatic wait_pin(input int k, input logic v, input int lim);
      int n;
   begin
      n = 0;
      while (pins[k] !== v && n < lim)
      begin
         @(posedge aclk);
         n++;
      end
      check(32'(pins[k]), 32'(v));
   end
   endtask : wait_pin

   // Write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
   begin
      @(posedge aclk);
      wr_q.push_back(er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      {aw, w, b} = 3'h7;
      while (aw || w || b)
      begin
         @(posedge aclk);
         aw = aw && awready !== 1'b1;
         w = w && wready !== 1'b1;
         b = b && bvalid !== 1'b1;
         awvalid <= aw;
         wvalid <= w;
         bready <= b;
      end
   end
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [33:0] ex);
      logic ar, rr;
   begin
      @(posedge aclk);
      rd_q.push_back(ex);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      {ar, rr} = 2'h3;
      while (ar || rr)
      begin
         @(posedge aclk);
         ar = ar && arready !== 1'b1;
         rr = rr && rvalid !== 1'b1;
         arvalid <= ar;
         rready <= rr;
      end
   end
   endtask : axi_rd

   task automatic summarize();
   begin
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask : summarize

   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(95288));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`QMM_OFS_STATUS, {`QMM_RESP_OKAY, 32'h1});
      check(32'(pins), 32'h1);
      axi_rd(`QMM_OFS_MASK, {`QMM_RESP_OKAY, 32'h0});
      axi_rd(`QMM_OFS_CTRL, {`QMM_RESP_OKAY, 32'h0});
      axi_rd(8'h10, {`QMM_RESP_SLVERR, 32'h0});
      axi_wr(8'h10, 32'h1, `QMM_RESP_SLVERR);
      axi_wr(`QMM_OFS_STATUS, 32'hF, `QMM_RESP_SLVERR);
      $display("test reset done");
      // Data ready after power-on, then again after a module reset pulse
      for (int p = 0; p < 2; p++)
      begin
         if (p == 1)
         begin
            i_host.pins(1'b0, 1'b1, 1'b0);
            repeat (4) @(posedge aclk);
            axi_rd(`QMM_OFS_STATUS, {`QMM_RESP_OKAY, 32'h1});
            i_host.pins(1'b1, 1'b1, 1'b0);
         end
         wait_pin(0, 1'b0, RDY + 20); // Ready shown on interrupt
         axi_rd(`QMM_OFS_STATUS, {`QMM_RESP_OKAY, 32'h0}); // Not-ready bit cleared
         axi_rd(`QMM_OFS_FLAGS, {`QMM_RESP_OKAY, 32'h100}); // Host reads flags
         wait_pin(0, 1'b1, T_CLR); // Read releases interrupt
      end
      $display("test ready done");
      // Each condition raises its flag and the interrupt; read clears
      for (int i = 0; i < 8; i++)
      begin
         cond <= 8'(8'h01 << i);
         wait_pin(0, 1'b0, T_MS); // Interrupt follows condition
         cond <= 8'h00;
         repeat (4) @(posedge aclk);
         axi_rd(`QMM_OFS_FLAGS, {`QMM_RESP_OKAY, 32'(9'h001 << i)}); // Flag set
         wait_pin(0, 1'b1, T_CLR); // Clear on read
      end
      $display("test flags done");
      // Mask keeps a flag off the interrupt
      r = $urandom;
      axi_wr(`QMM_OFS_MASK, r, `QMM_RESP_OKAY);
      axi_rd(`QMM_OFS_MASK, {`QMM_RESP_OKAY, r & 32'h1FF});
      m = 9'(9'h001 << (1 + $urandom_range(6)));
      axi_wr(`QMM_OFS_MASK, 32'(m), `QMM_RESP_OKAY);
      cond <= m[7:0];
      repeat (20) @(posedge aclk);
      check(32'(irq_n), 32'h1); // Masked flag does not interrupt
      axi_wr(`QMM_OFS_MASK, 32'h0, `QMM_RESP_OKAY);
      wait_pin(0, 1'b0, T_MS); // Unmask lets it interrupt
      axi_wr(`QMM_OFS_MASK, 32'(m), `QMM_RESP_OKAY);
      wait_pin(0, 1'b1, T_MS); // Mask set while flag set
      cond <= 8'h00;
      repeat (4) @(posedge aclk);
      axi_rd(`QMM_OFS_FLAGS, {`QMM_RESP_OKAY, 32'(m)}); // Masked flag still recorded
      axi_wr(`QMM_OFS_MASK, 32'h0, `QMM_RESP_OKAY);
      repeat (10) @(posedge aclk);
      check(32'(irq_n), 32'h1); // No flag left set
      $display("test mask done");
      // Low power pin, then the power-down bit
      i_host.pins(1'b1, 1'b1, 1'b1);
      wait_pin(1, 1'b1, T_US); // Pin lowers power
      axi_rd(`QMM_OFS_STATUS, {`QMM_RESP_OKAY, 32'h2});
      i_host.pins(1'b1, 1'b1, 1'b0);
      wait_pin(1, 1'b0, T_US);
      axi_wr(`QMM_OFS_CTRL, 32'h1, `QMM_RESP_OKAY);
      wait_pin(1, 1'b1, T_MS); // Power-down set
      axi_rd(`QMM_OFS_CTRL, {`QMM_RESP_OKAY, 32'h1});
      axi_wr(`QMM_OFS_CTRL, 32'h0, `QMM_RESP_OKAY);
      wait_pin(1, 1'b0, T_MS); // Power-down cleared
      $display("test power done");
      // Select gates serial responses; a frame shows the bus busy
      i_host.pins(1'b1, 1'b0, 1'b0);
      wait_pin(2, 1'b1, T_US); // Select enables responses
      fork
         i_host.frame(8'($urandom));
         begin
            repeat (30) @(posedge aclk);
            axi_rd(`QMM_OFS_STATUS, {`QMM_RESP_OKAY, 32'hC}); // Busy inside frame
         end
      join
      repeat (5) @(posedge aclk);
      axi_rd(`QMM_OFS_STATUS, {`QMM_RESP_OKAY, 32'h4});
      i_host.pins(1'b1, 1'b1, 1'b0);
      wait_pin(2, 1'b0, T_US); // Deselect stops responses
      $display("test select done");
      summarize();
   end

   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      summarize();
   end
endmodule : qmm_top_tb
